// >>> i2c_host_model.sv
// i2c host model for the management bus
// assumes the bench resolves the wired-and data line into sda_line
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model (
  input wire logic sys_clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_drv
);
  // idle bus: clock stands high, data released
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // half scl phase, long enough for the pin filter
  task automatic hp();
    repeat (10) @(posedge sys_clk);
    #1;
  endtask
  task automatic start_c();
    hp();
    sda_drv = 1'b0;
    hp();
    scl = 1'b0;
  endtask
  task automatic stop_c();
    hp();
    sda_drv = 1'b0;
    hp();
    scl = 1'b1;
    hp();
    sda_drv = 1'b1;
  endtask
  // nine clocks; data moves mid low phase so it never races the fall
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
    logic s;
    for (int i = 7; i >= -1; i--) begin
      repeat (4) @(posedge sys_clk);
      #1;
      sda_drv = (i < 0) ? 1'b1 : tx[i];
      hp();
      scl = 1'b1;
      hp();
      s = sda_line;
      if (i >= 0) rx[i] = s;
      scl = 1'b0;
    end
    ack = ~s;
  endtask
endmodule // i2c_host_model
`default_nettype wire

// >>> pin_sync.sv
// three-stage pin synchroniser with agreement filter
// assumes inputs are asynchronous to sys_clk
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 2
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level_q
);
  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  // first stage feeds only the second; bus idles high
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s1_q <= '1;
      s2_q <= '1;
      s3_q <= '1;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // a change counts once stages two and three agree
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      level_q <= '1;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          level_q[i] <= s3_q[i];
        end
      end
    end
  end
endmodule // pin_sync
`default_nettype wire

// >>> pointer_decode_params.svh
// constants for the register pointer decode block
// assumes inclusion by the top module only
`ifndef POINTER_DECODE_PARAMS_SVH
`define POINTER_DECODE_PARAMS_SVH

`define PD_BYTE_BITS 4'h8
`define PD_PTR_RESET 8'h00
`define PD_PTR_MASK 8'h7B
`define PD_CTRL_MASK 8'h3F
`define PD_TEST_MASK 8'h7E
`define PD_REG_RESET 8'h00

`define PD_SEL_COMMON_STATUS 4'h0
`define PD_SEL_COMMON_CTRL 4'h1
`define PD_SEL_PORT_CTRL1 4'h2
`define PD_SEL_PORT_CTRL2 4'h3
`define PD_SEL_PORT_STAT1 4'h4
`define PD_SEL_PORT_STAT2 4'h5
`define PD_SEL_DISC_LO 4'h6
`define PD_SEL_DISC_HI 4'h7
`define PD_SEL_VOLT_LO 4'h8
`define PD_SEL_VOLT_HI 4'h9
`define PD_SEL_CURR_LO 4'hA
`define PD_SEL_CURR_HI 4'hB
`define PD_SEL_TEMP_LO 4'hC
`define PD_SEL_TEMP_HI 4'hD
`define PD_SEL_NONE 4'hE
`define PD_SEL_TEST 4'hF

`endif

// >>> pointer_decode_pkg.sv
// types shared by the pointer decode block
// assumes the params header sits in the same folder
package pointer_decode_pkg;

  // pointer byte layout, msb first
  typedef struct packed {
    logic spare_hi;
    logic [3:0] sel;
    logic spare_lo;
    logic [1:0] port;
  } pointer_t;

  // per-port readable bytes from the measurement side
  typedef struct packed {
    logic [7:0] stat1;
    logic [7:0] stat2;
    logic [7:0] disc_lo;
    logic [7:0] disc_hi;
    logic [7:0] volt_lo;
    logic [7:0] volt_hi;
    logic [7:0] curr_lo;
    logic [7:0] curr_hi;
  } port_meas_t;

  // common readable inputs
  typedef struct packed {
    logic [3:0] port_fault;
    logic [1:0] chip_rev;
    logic [7:0] temp_lo;
    logic [7:0] temp_hi;
  } common_in_t;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_PTR,
    ST_PTR_ACK,
    ST_WDATA,
    ST_WDATA_ACK,
    ST_RDATA,
    ST_RDATA_ACK
  } bus_state_t;

endpackage

// >>> register_pointer_decode.sv
// i2c target front end with register/port pointer decode and register bank
// assumes scl and sda_in come straight from pins; sda output is open-drain
`timescale 1ns/1ps
`default_nettype none
`include "pointer_decode_params.svh"
module register_pointer_decode
  import pointer_decode_pkg::*;
#(
  parameter logic [1:0] CHIP_ID = 2'h1 // arbitrary value
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [4:0] dev_addr,
  input wire common_in_t common_in,
  input wire port_meas_t [3:0] port_meas,
  output pointer_t pointer_q,
  output logic [7:0] common_ctrl_q,
  output logic [7:0] test_ctrl_q,
  output logic [3:0][7:0] port_ctrl1_q,
  output logic [3:0][7:0] port_ctrl2_q
);
  logic [1:0] pins_q;
  logic scl_q;
  logic sda_q;
  logic scl_prev_q;
  logic sda_prev_q;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  bus_state_t state_q;
  logic [3:0] bit_cnt_q;
  logic [7:0] shift_q;
  logic [7:0] rdata_q;
  logic rw_q;
  logic oe_q;
  logic byte_done;
  logic wr_strobe;
  logic [7:0] rd_next;

  // read side mux for the current pointer
  function automatic logic [7:0] read_value(input pointer_t p, input common_in_t c,
                                            input port_meas_t [3:0] m);
    port_meas_t pm;
    pm = m[p.port];
    unique case (p.sel)
      `PD_SEL_COMMON_STATUS: read_value = {c.port_fault, c.chip_rev, CHIP_ID};
      `PD_SEL_PORT_STAT1: read_value = pm.stat1;
      `PD_SEL_PORT_STAT2: read_value = pm.stat2;
      `PD_SEL_DISC_LO: read_value = pm.disc_lo;
      `PD_SEL_DISC_HI: read_value = pm.disc_hi;
      `PD_SEL_VOLT_LO: read_value = pm.volt_lo;
      `PD_SEL_VOLT_HI: read_value = pm.volt_hi;
      `PD_SEL_CURR_LO: read_value = pm.curr_lo;
      `PD_SEL_CURR_HI: read_value = pm.curr_hi;
      `PD_SEL_TEMP_LO: read_value = c.temp_lo;
      `PD_SEL_TEMP_HI: read_value = c.temp_hi;
      // write-only selects and the unmapped code read as zero
      default: read_value = `PD_REG_RESET;
    endcase
  endfunction

  pin_sync #(.WIDTH(2)) u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .pin_in({scl, sda_in}),
    .level_q(pins_q)
  );
  assign scl_q = pins_q[1];
  assign sda_q = pins_q[0];

  // byte the stored pointer would return; a named net, since a call result takes no bit-select
  assign rd_next = read_value(pointer_q, common_in, port_meas);

  // edge history of the filtered pins
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_prev_q <= scl_q;
      sda_prev_q <= sda_q;
    end
  end

  assign scl_rise = scl_q & ~scl_prev_q;
  assign scl_fall = ~scl_q & scl_prev_q;
  // sda moving while scl stays high frames a transfer
  assign start_cond = scl_q & scl_prev_q & sda_prev_q & ~sda_q;
  assign stop_cond = scl_q & scl_prev_q & ~sda_prev_q & sda_q;
  assign byte_done = scl_fall & (bit_cnt_q == `PD_BYTE_BITS);
  assign wr_strobe = byte_done & (state_q == ST_WDATA);

  // shift register and bit counter; receive on rise, count on fall for reads
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      shift_q <= `PD_REG_RESET;
      bit_cnt_q <= '0;
    end else if (start_cond) begin
      bit_cnt_q <= '0;
    end else if (scl_rise && (state_q == ST_ADDR || state_q == ST_PTR
                 || state_q == ST_WDATA)) begin
      shift_q <= {shift_q[6:0], sda_q};
      bit_cnt_q <= bit_cnt_q + 4'h1;
    end else if (scl_fall && state_q == ST_RDATA) begin
      bit_cnt_q <= bit_cnt_q + 4'h1;
    end else if (scl_fall && bit_cnt_q == `PD_BYTE_BITS) begin
      bit_cnt_q <= '0;
    end
  end

  // transfer sequencing; a stop or a fresh start always wins
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
      rw_q <= 1'b0;
    end else if (start_cond) begin
      state_q <= ST_ADDR;
    end else if (stop_cond) begin
      state_q <= ST_IDLE;
    end else if (scl_fall) begin
      unique case (state_q)
        ST_IDLE: state_q <= ST_IDLE;
        ST_ADDR: begin
          if (bit_cnt_q == `PD_BYTE_BITS) begin
            // top two address bits are never compared
            state_q <= (shift_q[5:1] == dev_addr) ? ST_ADDR_ACK : ST_IDLE;
            rw_q <= shift_q[0];
          end
        end
        ST_ADDR_ACK: state_q <= rw_q ? ST_RDATA : ST_PTR;
        ST_PTR: begin
          if (bit_cnt_q == `PD_BYTE_BITS) begin
            state_q <= ST_PTR_ACK;
          end
        end
        ST_PTR_ACK: state_q <= ST_WDATA;
        ST_WDATA: begin
          if (bit_cnt_q == `PD_BYTE_BITS) begin
            state_q <= ST_WDATA_ACK;
          end
        end
        ST_WDATA_ACK: state_q <= ST_WDATA;
        ST_RDATA: begin
          if (bit_cnt_q == `PD_BYTE_BITS - 4'h1) begin
            state_q <= ST_RDATA_ACK;
          end
        end
        // host answers the single read byte, then must stop
        ST_RDATA_ACK: state_q <= ST_IDLE;
      endcase
    end
  end

  // pointer taken at the fall ending bit eight
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      // reset to status and first port
      pointer_q <= `PD_PTR_RESET;
    end else if (byte_done && state_q == ST_PTR) begin
      pointer_q <= shift_q & `PD_PTR_MASK;
    end
  end

  // read byte captured as the address ack ends, so it holds steady
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdata_q <= `PD_REG_RESET;
    end else if (scl_fall && state_q == ST_ADDR_ACK && rw_q) begin
      rdata_q <= rd_next;
    end else if (scl_fall && state_q == ST_RDATA) begin
      rdata_q <= {rdata_q[6:0], 1'b0};
    end
  end

  // open-drain drive: ack low for one clock, read bits msb first
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      oe_q <= 1'b0;
    end else if (start_cond || stop_cond) begin
      oe_q <= 1'b0;
    end else if (scl_fall) begin
      unique case (state_q)
        ST_ADDR: oe_q <= byte_done && (shift_q[5:1] == dev_addr);
        ST_PTR: oe_q <= byte_done;
        ST_WDATA: oe_q <= byte_done;
        ST_ADDR_ACK: oe_q <= rw_q ? ~rd_next[7] : 1'b0;
        ST_RDATA: oe_q <= (bit_cnt_q == `PD_BYTE_BITS - 4'h1) ? 1'b0 : ~rdata_q[6];
        default: oe_q <= 1'b0;
      endcase
    end
  end
  assign sda_oe = oe_q;
  assign sda_out = 1'b0;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      common_ctrl_q <= `PD_REG_RESET;
    end else if (wr_strobe && pointer_q.sel == `PD_SEL_COMMON_CTRL) begin
      common_ctrl_q <= shift_q & `PD_CTRL_MASK;
    end
  end

  // test register write; code 1110 stores nowhere
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      test_ctrl_q <= `PD_REG_RESET;
    end else if (wr_strobe && pointer_q.sel == `PD_SEL_TEST) begin
      test_ctrl_q <= shift_q & `PD_TEST_MASK;
    end
  end

  // per-port writes touch the selected port only
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      port_ctrl1_q <= '0;
      port_ctrl2_q <= '0;
    end else if (wr_strobe) begin
      if (pointer_q.sel == `PD_SEL_PORT_CTRL1) begin
        port_ctrl1_q[pointer_q.port] <= shift_q;
      end
      if (pointer_q.sel == `PD_SEL_PORT_CTRL2) begin
        port_ctrl2_q[pointer_q.port] <= shift_q;
      end
    end
  end
endmodule // register_pointer_decode
`default_nettype wire

// >>> register_pointer_decode_assertions.sv
// concurrent checks on the pointer decode ports
// assumes one sys_clk domain and a synchronous active-high rst
`timescale 1ns/1ps
`default_nettype none
module register_pointer_decode_assertions
  import pointer_decode_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire pointer_t pointer_q,
  input wire logic [7:0] common_ctrl_q,
  input wire logic [7:0] test_ctrl_q,
  input wire logic [3:0][7:0] port_ctrl1_q,
  input wire logic [3:0][7:0] port_ctrl2_q
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // stored layout and unused bits
  a_spare_bits_zero: assert property (!pointer_q.spare_hi && !pointer_q.spare_lo)
    else $error("pointer spare bit set");
  a_ctrl_unused_zero: assert property (common_ctrl_q[7:6] == 2'h0)
    else $error("common control unused bits set");
  a_test_unused_zero: assert property (!test_ctrl_q[7] && !test_ctrl_q[0])
    else $error("test register unused bits set");
  a_reset_clear: assert property ($fell(rst) |->
    pointer_q == 8'h00 && common_ctrl_q == 8'h00)
    else $error("registers not cleared by reset");
  // open drain: only ever pulls low, and holds still while scl is high
  a_oe_drives_low: assert property (sda_oe |-> !sda_out)
    else $error("data output drives high");
  a_oe_stable_high: assert property (scl && $past(scl) |-> $stable(sda_oe))
    else $error("data output moved while scl high");
  // updates land after an scl fall and are acknowledged
  a_ptr_on_fall: assert property ($changed(pointer_q) |-> !scl ##[0:3] sda_oe)
    else $error("pointer changed without fall and ack");
  a_ctrl_acked: assert property ($changed(common_ctrl_q) || $changed(test_ctrl_q)
    |-> !scl ##[0:3] sda_oe)
    else $error("common write without ack");
  for (genvar k = 0; k < 4; k++) begin : g_port
    a_ctrl1_one_port: assert property ($changed(port_ctrl1_q[k])
      |-> pointer_q.port == k && pointer_q.sel == 4'h2)
      else $error("port control one hit wrong port");
    a_ctrl2_one_port: assert property ($changed(port_ctrl2_q[k])
      |-> pointer_q.port == k && pointer_q.sel == 4'h3)
      else $error("port control two hit wrong port");
  end
  c_ptr_write: cover property ($changed(pointer_q));
  c_ack_seen: cover property ($rose(sda_oe));
  c_port_write: cover property ($changed(port_ctrl2_q));
endmodule // register_pointer_decode_assertions
bind register_pointer_decode register_pointer_decode_assertions chk_u (
  .sys_clk(sys_clk), .rst(rst), .scl(scl), .sda_out(sda_out), .sda_oe(sda_oe),
  .pointer_q(pointer_q), .common_ctrl_q(common_ctrl_q), .test_ctrl_q(test_ctrl_q),
  .port_ctrl1_q(port_ctrl1_q), .port_ctrl2_q(port_ctrl2_q)
);
`default_nettype wire

// >>> tb.sv
// self-checking bench for the register pointer decode block
// assumes the host model drives the pins and the checker is bound in
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin num_errors++; \
  $display("[FAIL] %0t got %h want %h", $time, g, e); end end
module tb
  import pointer_decode_pkg::*;
;
  localparam logic [1:0] ID_VAL = 2'h3; // arbitrary value
  logic sys_clk, rst, scl, sda_drv, sda_out, sda_oe, sda_line, ack;
  logic [4:0] dev_addr;
  logic [7:0] rx, p, d;
  common_in_t common_in;
  port_meas_t [3:0] port_meas;
  pointer_t pointer_q;
  logic [7:0] common_ctrl_q, test_ctrl_q;
  logic [3:0][7:0] port_ctrl1_q, port_ctrl2_q;
  int num_errors, cmp_count, seed, cyc, acks, m_ptr, m_cc, m_tc;
  int m_c1[4], m_c2[4];
  // wired-and data line with pull-up
  assign sda_line = sda_drv & ~(sda_oe & ~sda_out);
  i2c_host_model host_u (.sys_clk(sys_clk), .sda_line(sda_line), .scl(scl), .sda_drv(sda_drv));
  register_pointer_decode #(.CHIP_ID(ID_VAL)) dut_u (
    .sys_clk(sys_clk), .rst(rst), .scl(scl), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe(sda_oe), .dev_addr(dev_addr), .common_in(common_in), .port_meas(port_meas),
    .pointer_q(pointer_q), .common_ctrl_q(common_ctrl_q), .test_ctrl_q(test_ctrl_q),
    .port_ctrl1_q(port_ctrl1_q), .port_ctrl2_q(port_ctrl2_q)
  );
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // byte a read should return for pointer p
  function automatic logic [7:0] exp_rd(input logic [7:0] p);
    int s;
    s = p[6:3];
    if (s == 0) return {common_in.port_fault, common_in.chip_rev, ID_VAL};
    if (s >= 4 && s <= 11) return port_meas[p[1:0]][8 * (11 - s) +: 8];
    if (s == 12) return common_in.temp_lo;
    if (s == 13) return common_in.temp_hi;
    return 8'h00;
  endfunction
  // model of a full write frame
  task automatic model_wr(input logic [7:0] p, input logic [7:0] d);
    m_ptr = p & 8'h7B;
    case (p[6:3])
      4'h1: m_cc = d & 8'h3F;
      4'h2: m_c1[p[1:0]] = d;
      4'h3: m_c2[p[1:0]] = d;
      4'hF: m_tc = d & 8'h7E;
      default: ;
    endcase
  endtask
  task automatic chk_regs();
    `CHK(pointer_q, m_ptr[7:0])
    `CHK(common_ctrl_q, m_cc[7:0])
    `CHK(test_ctrl_q, m_tc[7:0])
    for (int k = 0; k < 4; k++) begin
      `CHK(port_ctrl1_q[k], m_c1[k][7:0])
      `CHK(port_ctrl2_q[k], m_c2[k][7:0])
    end
  endtask
  // write frame of n bytes; ax flips address bits to miss the device
  task automatic put(input logic [7:0] p, input logic [7:0] d, input int n, input logic [4:0] ax);
    logic [7:0] r;
    logic [7:0] b[3];
    b = '{{2'($random(seed)), dev_addr ^ ax, 1'b0}, p, d};
    acks = 0;
    host_u.start_c();
    for (int i = 0; i < n; i++) begin
      host_u.xfer(b[i], r, ack);
      // an unknown line would pass as no-ack
      `CHK($isunknown(ack), 1'b0)
      acks += ack;
    end
    host_u.stop_c();
  endtask
  task automatic get(output logic [7:0] r);
    host_u.start_c();
    host_u.xfer({2'($random(seed)), dev_addr, 1'b1}, r, ack);
    acks = ack;
    `CHK($isunknown(ack), 1'b0)
    host_u.xfer(8'hFF, r, ack);
    // line released for the host answer
    `CHK(ack, 1'b0)
    host_u.stop_c();
  endtask
  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // hang guard, well above the roughly 55k cycles the run needs
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 90000) begin
      num_errors++;
      close_out();
    end
  end
  initial begin
    seed = 77;
    {num_errors, cmp_count, cyc, m_ptr, m_cc, m_tc} = '0;
    m_c1 = '{default: 0};
    m_c2 = '{default: 0};
    rst = 1'b1;
    dev_addr = 5'h13;
    common_in = '0;
    port_meas = '0;
    repeat (12) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    chk_regs();
    get(rx);
    `CHK(rx, exp_rd(8'h00))
    $display("test reset done");
    for (int i = 0; i < 32; i++) begin
      p = {1'b0, 4'(i), 1'b0, 2'($random(seed))};
      d = 8'($random(seed));
      common_in = 22'($random(seed));
      for (int k = 0; k < 4; k++) port_meas[k] = {$random(seed), $random(seed)};
      put(p, d, 3, 5'h00);
      `CHK(acks, 3)
      model_wr(p, d);
      chk_regs();
      put(p, 8'h00, 2, 5'h00);
      `CHK(acks, 2)
      get(rx);
      `CHK(acks, 1)
      `CHK(rx, exp_rd(p))
    end
    $display("test select sweep done");
    put(8'h08, 8'hFF, 3, 5'h04);
    `CHK(acks, 0)
    chk_regs();
    $display("test wrong address done");
    // second reset mid-run, with the registers holding written values
    rst = 1'b1;
    repeat (12) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    m_ptr = 0;
    m_cc = 0;
    m_tc = 0;
    m_c1 = '{default: 0};
    m_c2 = '{default: 0};
    chk_regs();
    get(rx);
    `CHK(rx, exp_rd(8'h00))
    $display("test mid-run reset done");
    close_out();
  end
endmodule // tb
`default_nettype wire
